// ===== rtl/sts_supervisor.sv
// Supply short, undervoltage and thermal supervision logic
//
// Functional notes
// - Short detection armed only while battery supply is above undervoltage.
// - Main supply not up within filter time forces short reaction, fail-safe.
// - Fail-safe after short is left only on bus, wake or gpio wake.
// - Main supply below threshold longer than filter time gives same reaction.
// - Aux enabled and undervoltage sets aux flag; only serial write clears.
// - Aux undervoltage flag suppressed during blanking and switching.
// - Transceiver enabled and its supply low sets flag; serial write clears.
// - Block overtemperature turns that block off, sets block shutdown flag.
// - Block thermal shutdown evaluated only while that block is on.
// - Aux overtemperature clears aux enables, sets aux overtemperature status.
// - Transceiver overtemperature disables transmitter, fail field 01, auto recovery.
// - Thermal flags never self-clear; controller clears after condition ends.
// - Main prewarning sets flag; clear only once prewarning gone.
// - Chip thermal shutdown event enters fail-safe immediately.
// - After cooling, wait time in fail-safe, then restart, then normal.
// - Chip shutdown flag set per event; clear only in normal, cool.
// - With extend bit, wait is 64 times base after 16 events.
// - Counter counts events and holds at 16; at 16 sets safe latch, extended wait.
// - Extended wait kept until safe latch cleared; counter reset on clears.
// - Chip shutdown during sleep entry goes to fail-safe instead.
// - Raise bit selects thresholds raised by 10 kelvin.
// - Main overvoltage comparator qualified by a 64 us filter.
// - Short filter and power-up blanking are 2 ms, battery above undervoltage.
// - Aux blanking after switch-on is 4 ms.
`timescale 1ns/10ps
module sts_supervisor
    import sts_pkg::*;
#(
    parameter int SHORT_CYC = sts_pkg::SHORT_FILTER_CYC,
    parameter int BLANK_CYC = sts_pkg::AUX_BLANK_CYC,
    parameter int COOL_CYC  = sts_pkg::COOL_BASE_CYC
)(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             battery_ok,
    input  wire logic             main_supply_ok,
    input  wire logic             main_ov_cmp,
    input  wire logic             aux_supply_ok,
    input  wire logic             transceiver_supply_ok,
    input  wire logic             aux_hot,
    input  wire logic             bus_hot,
    input  wire logic             main_prewarn_hot,
    input  wire logic             chip_hot,
    input  wire logic             bus_wake,
    input  wire logic             wake_input,
    input  wire logic             gpio_wake,
    input  wire logic             gpio_is_wake,
    input  wire logic             transceiver_en,
    input  wire logic             sleep_req,
    input  wire logic             aux_on_wr,
    input  wire logic [1:0]       aux_on_data,
    input  wire logic             shutdown_delay_extend_wr,
    input  wire logic             shutdown_delay_extend_data,
    input  wire logic             thermal_threshold_raise_in,
    input  wire logic [7:0]       clear_wr,
    output logic [1:0]            aux_enable_bits,
    output logic                  main_short_flag,
    output logic                  main_supply_en,
    output logic                  fail_output,
    output logic                  flag_a,
    output logic                  aux_undervoltage_flag,
    output logic                  transceiver_supply_uv_flag,
    output logic                  block_thermal_shutdown_flag,
    output logic                  aux_overtemp_flag,
    output logic                  temp_prewarning_flag,
    output logic                  chip_thermal_shutdown_flag,
    output logic                  shutdown_safe_latch,
    output logic                  shutdown_delay_extend,
    output logic                  thermal_threshold_raise,
    output logic                  tx_enable,
    output logic [1:0]            bus_fail,
    output logic                  main_ov_event,
    output sts_pkg::sts_mode_t    mode
);
    import sts_pkg::*;

    initial
    begin
        if (SHORT_CYC < 1 || BLANK_CYC < 1 || COOL_CYC < 1)
            $error("sts_supervisor: counts must be positive");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 12;
    // Supply-ok bits start high so reset release raises no false undervoltage
    localparam logic [NSYNC-1:0] SYNC_IDLE = 12'h01B;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sy;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= SYNC_IDLE;
            sy    <= SYNC_IDLE;
        end
        else
        begin
            sync1 <= {gpio_wake, wake_input, bus_wake, chip_hot, main_prewarn_hot, bus_hot,
                      aux_hot, transceiver_supply_ok, aux_supply_ok, main_ov_cmp,
                      main_supply_ok, battery_ok};
            sy    <= sync1;
        end
    end
    logic s_bat, s_main, s_ov, s_aux, s_xcv, s_aux_hot, s_bus_hot, s_pw, s_chip, s_wake;
    assign s_bat     = sy[0];
    assign s_main    = sy[1];
    assign s_ov      = sy[2];
    assign s_aux     = sy[3];
    assign s_xcv     = sy[4];
    assign s_aux_hot = sy[5];
    assign s_bus_hot = sy[6];
    assign s_pw      = sy[7];
    assign s_chip    = sy[8];
    assign s_wake    = sy[9] | sy[10] | (sy[11] & gpio_is_wake);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] sc_cnt, next_sc_cnt, bl_cnt, next_bl_cnt, ov_cnt, next_ov_cnt, cool_cnt, next_cool_cnt;
    logic [4:0]  ev_cnt, next_ev_cnt;
    logic        chip_hot_d, next_chip_hot_d, short_lock, next_short_lock;
    logic [1:0]  aux_prev, next_aux_prev;
    sts_mode_t   next_mode;
    logic [1:0]  next_aux_en, next_bus_fail;
    logic        next_sc, next_men, next_fo, next_fa, next_auv, next_xuv, next_block_thermal_shutdown_flag, next_aot;
    logic        next_tpw, next_chip_thermal_shutdown_flag, next_safe, next_del, next_raise, next_tx, next_ov;

    always_comb
    begin
        next_sc_cnt     = sc_cnt;
        next_bl_cnt     = bl_cnt;
        next_ov_cnt     = ov_cnt;
        next_cool_cnt   = cool_cnt;
        next_ev_cnt     = ev_cnt;
        next_chip_hot_d = s_chip;
        next_short_lock = short_lock;
        next_mode       = mode;
        next_aux_en     = aux_enable_bits;
        next_aux_prev   = aux_enable_bits;
        next_sc         = main_short_flag;
        next_men        = main_supply_en;
        next_fo         = fail_output;
        next_fa         = flag_a;
        next_auv        = aux_undervoltage_flag;
        next_xuv        = transceiver_supply_uv_flag;
        next_block_thermal_shutdown_flag       = block_thermal_shutdown_flag;
        next_aot        = aux_overtemp_flag;
        next_tpw        = temp_prewarning_flag;
        next_chip_thermal_shutdown_flag       = chip_thermal_shutdown_flag;
        next_safe       = shutdown_safe_latch;
        next_del        = shutdown_delay_extend;
        next_raise      = thermal_threshold_raise_in;
        next_tx         = tx_enable;
        next_bus_fail   = bus_fail;
        next_ov         = 1'b0;

        // Serial clears first so that hardware sets below win
        if (aux_on_wr)
            next_aux_en = aux_on_data;
        if (shutdown_delay_extend_wr)
            next_del = shutdown_delay_extend_data;
        if (clear_wr[0]) next_auv = 1'b0;
        if (clear_wr[1]) next_xuv = 1'b0;
        if (clear_wr[2] && !s_aux_hot && !s_bus_hot) next_block_thermal_shutdown_flag = 1'b0;
        if (clear_wr[3] && !s_aux_hot) next_aot = 1'b0;
        if (clear_wr[4] && !s_pw) next_tpw = 1'b0;
        if (clear_wr[5] && !s_chip && mode == STS_NORMAL) next_chip_thermal_shutdown_flag = 1'b0;
        // extended wait until safe latch cleared
        if (clear_wr[6]) next_safe = 1'b0;
        if (clear_wr[7]) begin next_sc = 1'b0; next_fa = 1'b0; end
        if ((chip_thermal_shutdown_flag && !next_chip_thermal_shutdown_flag) || (shutdown_delay_extend && !next_del))
            next_ev_cnt = 5'h0;

        if (!s_ov)
            next_ov_cnt = 32'h0;
        else if (ov_cnt < 32'(OV_FILTER_CYC))
            next_ov_cnt = ov_cnt + 32'h1;
        next_ov = s_ov && ov_cnt == 32'(OV_FILTER_CYC - 1);

        if (!s_bat || s_main || !main_supply_en)
            next_sc_cnt = 32'h0;
        else if (sc_cnt < 32'(SHORT_CYC))
            next_sc_cnt = sc_cnt + 32'h1;

        if (aux_enable_bits == 2'h0 || aux_enable_bits != aux_prev)
            next_bl_cnt = 32'h0;
        else if (bl_cnt < 32'(BLANK_CYC))
            next_bl_cnt = bl_cnt + 32'h1;
        if (aux_enable_bits != 2'h0 && aux_prev == aux_enable_bits && bl_cnt >= 32'(BLANK_CYC) && !aux_on_wr && !s_aux)
            next_auv = 1'b1;
        if (transceiver_en && !s_xcv)
            next_xuv = 1'b1;

        if (aux_enable_bits != 2'h0 && s_aux_hot)
        begin
            next_aux_en = AUX_ON_RESET;
            next_aot = 1'b1;
            next_block_thermal_shutdown_flag = 1'b1;
        end
        if (transceiver_en && s_bus_hot)
        begin
            next_tx = 1'b0;
            next_bus_fail = BUS_FAIL_OT;
            next_block_thermal_shutdown_flag = 1'b1;
        end
        else if (!s_bus_hot)
            next_tx = transceiver_en;
        if (s_pw) next_tpw = 1'b1;

        // Mode handling; wait time re-armed while hot
        case (mode)
            STS_NORMAL, STS_SLEEP:
            begin
                if (sleep_req && mode == STS_NORMAL)
                    next_mode = STS_SLEEP;
                if (mode == STS_SLEEP && s_wake)
                    next_mode = STS_NORMAL;
            end
            STS_FAILSAFE:
            begin
                if (short_lock)
                begin
                    if (s_wake)
                    begin
                        next_short_lock = 1'b0;
                        next_men = 1'b1;
                        next_fo = 1'b0;
                        next_mode = STS_RESTART;
                    end
                end
                else if (s_chip)
                    next_cool_cnt = 32'h0;
                else if (cool_cnt >= (shutdown_safe_latch ? 32'(COOL_CYC * COOL_EXT_FACTOR) : 32'(COOL_CYC)) - 32'h1)
                begin
                    next_mode = STS_RESTART;
                    next_men = 1'b1;
                    next_fo = 1'b0;
                end
                else
                    next_cool_cnt = cool_cnt + 32'h1;
            end
            STS_RESTART:
                next_mode = STS_NORMAL;
            default:
                next_mode = STS_FAILSAFE;
        endcase

        // short reaction
        // Placed after mode handling so sleep or restart cannot override it
        if (s_bat && main_supply_en && !s_main && sc_cnt == 32'(SHORT_CYC - 1))
        begin
            next_sc = 1'b1;
            next_men = 1'b0;
            next_fo = 1'b1;
            next_fa = 1'b1;
            next_short_lock = 1'b1;
            next_mode = STS_FAILSAFE;
        end

        // chip event wins, also over sleep entry
        if (s_chip && !chip_hot_d)
        begin
            next_mode = STS_FAILSAFE;
            next_cool_cnt = 32'h0;
            next_fo = 1'b1;
            next_chip_thermal_shutdown_flag = 1'b1;
            if (ev_cnt < 5'(EVENT_LIMIT))
                next_ev_cnt = ev_cnt + 5'h1;
            if (next_del && ev_cnt >= 5'(EVENT_LIMIT - 1))
                next_safe = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sc_cnt <= '0; bl_cnt <= '0; ov_cnt <= '0; cool_cnt <= '0; ev_cnt <= '0;
            chip_hot_d <= 1'b0; short_lock <= 1'b0; aux_prev <= 2'h0;
            mode <= STS_NORMAL; aux_enable_bits <= AUX_ON_RESET;
            main_short_flag <= 1'b0; main_supply_en <= 1'b1; fail_output <= 1'b0; flag_a <= 1'b0;
            aux_undervoltage_flag <= 1'b0; transceiver_supply_uv_flag <= 1'b0;
            block_thermal_shutdown_flag <= 1'b0; aux_overtemp_flag <= 1'b0;
            temp_prewarning_flag <= 1'b0; chip_thermal_shutdown_flag <= 1'b0;
            shutdown_safe_latch <= 1'b0; shutdown_delay_extend <= 1'b0;
            thermal_threshold_raise <= 1'b0;
            tx_enable <= 1'b0; bus_fail <= BUS_FAIL_NONE; main_ov_event <= 1'b0;
        end
        else
        begin
            sc_cnt <= next_sc_cnt; bl_cnt <= next_bl_cnt; ov_cnt <= next_ov_cnt; cool_cnt <= next_cool_cnt;
            ev_cnt <= next_ev_cnt; chip_hot_d <= next_chip_hot_d; short_lock <= next_short_lock;
            aux_prev <= next_aux_prev; mode <= next_mode; aux_enable_bits <= next_aux_en;
            main_short_flag <= next_sc; main_supply_en <= next_men; fail_output <= next_fo; flag_a <= next_fa;
            aux_undervoltage_flag <= next_auv; transceiver_supply_uv_flag <= next_xuv;
            block_thermal_shutdown_flag <= next_block_thermal_shutdown_flag; aux_overtemp_flag <= next_aot;
            temp_prewarning_flag <= next_tpw; chip_thermal_shutdown_flag <= next_chip_thermal_shutdown_flag;
            shutdown_safe_latch <= next_safe; shutdown_delay_extend <= next_del;
            thermal_threshold_raise <= next_raise;
            tx_enable <= next_tx; bus_fail <= next_bus_fail; main_ov_event <= next_ov;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chip_event_fs_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sy[8] && !chip_hot_d) |=> (mode == STS_FAILSAFE && chip_thermal_shutdown_flag))
        else $error("chip event did not enter fail-safe");
    short_react_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(main_short_flag) |-> (!main_supply_en && fail_output && flag_a && mode == STS_FAILSAFE))
        else $error("short reaction incomplete");
    short_batt_a: assert property (@(posedge clk) disable iff (!rst_n)
        !sy[0] |=> !$rose(main_short_flag))
        else $error("short detected with battery low");
    short_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
        (short_lock && mode == STS_FAILSAFE && !s_wake) |=> mode == STS_FAILSAFE)
        else $error("short fail-safe left without wake");
    aux_ot_a: assert property (@(posedge clk) disable iff (!rst_n)
        (aux_enable_bits != 2'h0 && sy[5]) |=> (aux_enable_bits == 2'h0 && aux_overtemp_flag && block_thermal_shutdown_flag))
        else $error("aux overtemperature reaction missing");
    bus_ot_a: assert property (@(posedge clk) disable iff (!rst_n)
        (transceiver_en && sy[6]) |=> (!tx_enable && bus_fail == BUS_FAIL_OT))
        else $error("transmitter not disabled");
    chip_thermal_shutdown_flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (chip_thermal_shutdown_flag && mode != STS_NORMAL) |=> chip_thermal_shutdown_flag)
        else $error("chip flag cleared outside normal");
    prewarn_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (temp_prewarning_flag && sy[7]) |=> temp_prewarning_flag)
        else $error("prewarning cleared while hot");
    restart_normal_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == STS_RESTART && !(sy[8] && !chip_hot_d)
            && !(sy[0] && main_supply_en && !sy[1] && sc_cnt == 32'(SHORT_CYC - 1))) |=> mode == STS_NORMAL)
        else $error("restart did not go to normal");
endmodule // sts_supervisor

// ===== rtl/sts_pkg.sv
// Package for the supply and thermal supervisor
package sts_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ            = 100;
    localparam int SHORT_FILTER_US    = 2000;
    localparam int AUX_BLANK_US       = 4000;
    localparam int OV_FILTER_US       = 64;
    localparam int COOL_BASE_US       = 1000;
    localparam int SHORT_FILTER_CYC   = SHORT_FILTER_US * CLK_MHZ;
    localparam int AUX_BLANK_CYC      = AUX_BLANK_US * CLK_MHZ;
    localparam int OV_FILTER_CYC      = OV_FILTER_US * CLK_MHZ;
    localparam int COOL_BASE_CYC      = COOL_BASE_US * CLK_MHZ;
    localparam int COOL_EXT_FACTOR    = 64;
    localparam int EVENT_LIMIT        = 16;
    localparam int RAISE_KELVIN       = 10;
    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [1:0] BUS_FAIL_NONE = 2'h0;
    localparam logic [1:0] BUS_FAIL_OT   = 2'h1;
    localparam logic [1:0] AUX_ON_RESET  = 2'h0;
    // ------------------------------------------------------------
    // Chip modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        STS_NORMAL    = 2'h0,
        STS_FAILSAFE  = 2'h1,
        STS_RESTART   = 2'h3,
        STS_SLEEP     = 2'h2
    } sts_mode_t;
endpackage

// ===== sim/sts_host_model.sv
// Controller model issuing status clears and control writes
`timescale 1ns/10ps
module sts_host_model (
    input  wire logic       clk,
    output logic [7:0]      clear_wr,
    output logic            aux_on_wr,
    output logic [1:0]      aux_on_data,
    output logic            shutdown_delay_extend_wr,
    output logic            shutdown_delay_extend_data
);
    initial
    begin
        clear_wr = 8'h00;
        aux_on_wr = 1'b0;
        aux_on_data = 2'h0;
        shutdown_delay_extend_wr = 1'b0;
        shutdown_delay_extend_data = 1'b0;
    end
    task automatic clr(input logic [7:0] m);
        @(posedge clk);
        clear_wr <= m;
        @(posedge clk);
        clear_wr <= 8'h00;
    endtask
    task automatic wr_aux(input logic [1:0] d);
        @(posedge clk);
        aux_on_wr <= 1'b1;
        aux_on_data <= d;
        @(posedge clk);
        aux_on_wr <= 1'b0;
        aux_on_data <= ~d;
    endtask
    task automatic wr_ext(input logic d);
        @(posedge clk);
        shutdown_delay_extend_wr <= 1'b1;
        shutdown_delay_extend_data <= d;
        @(posedge clk);
        shutdown_delay_extend_wr <= 1'b0;
        shutdown_delay_extend_data <= ~d;
    endtask
endmodule // sts_host_model

// ===== sim/testbench.sv
// Self-checking bench for the supply and thermal supervisor
`timescale 1ns/10ps
module testbench;
    import sts_pkg::*;
    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    // Short counts keep the run brief
    localparam int SC = 20;
    localparam int BC = 40;
    localparam int CC = 10;
    typedef struct packed {
        logic       bh;
        logic       pw;
        logic       xok;
        logic [7:0] clr;
        logic [5:0] exp;
    } sts_row_t;
    logic       clk, rst_n, battery_ok, main_supply_ok, main_ov_cmp, aux_supply_ok, transceiver_supply_ok;
    logic       aux_hot, bus_hot, main_prewarn_hot, chip_hot, bus_wake, wake_input, gpio_wake, gpio_is_wake;
    logic       transceiver_en, sleep_req, aux_on_wr, shutdown_delay_extend_wr, shutdown_delay_extend_data;
    logic       thermal_threshold_raise_in, main_short_flag, main_supply_en, fail_output, flag_a;
    logic       aux_undervoltage_flag, transceiver_supply_uv_flag, block_thermal_shutdown_flag;
    logic       aux_overtemp_flag, temp_prewarning_flag, chip_thermal_shutdown_flag, shutdown_safe_latch;
    logic       shutdown_delay_extend, thermal_threshold_raise, tx_enable, main_ov_event;
    logic [1:0] aux_on_data, aux_enable_bits, bus_fail;
    logic [7:0] clear_wr;
    sts_mode_t  mode;
    int         err_total, total_checks, n, cycles;
    sts_row_t   rows [10] = '{'{1'b0, 1'b0, 1'b1, 8'h00, 6'h04}, '{1'b1, 1'b0, 1'b1, 8'h00, 6'h11},
                              '{1'b1, 1'b0, 1'b1, 8'h04, 6'h11}, '{1'b0, 1'b0, 1'b1, 8'h00, 6'h15},
                              '{1'b0, 1'b0, 1'b1, 8'h04, 6'h05}, '{1'b0, 1'b1, 1'b1, 8'h00, 6'h0D},
                              '{1'b0, 1'b1, 1'b1, 8'h10, 6'h0D}, '{1'b0, 1'b0, 1'b1, 8'h10, 6'h05},
                              '{1'b0, 1'b0, 1'b0, 8'h00, 6'h25}, '{1'b0, 1'b0, 1'b1, 8'h02, 6'h05}};
    sts_supervisor #(.SHORT_CYC(SC), .BLANK_CYC(BC), .COOL_CYC(CC)) uut (
        .clk, .rst_n, .battery_ok, .main_supply_ok, .main_ov_cmp, .aux_supply_ok, .transceiver_supply_ok,
        .aux_hot, .bus_hot, .main_prewarn_hot, .chip_hot, .bus_wake, .wake_input, .gpio_wake, .gpio_is_wake,
        .transceiver_en, .sleep_req, .aux_on_wr, .aux_on_data, .shutdown_delay_extend_wr,
        .shutdown_delay_extend_data, .thermal_threshold_raise_in, .clear_wr, .aux_enable_bits,
        .main_short_flag, .main_supply_en, .fail_output, .flag_a, .aux_undervoltage_flag,
        .transceiver_supply_uv_flag, .block_thermal_shutdown_flag, .aux_overtemp_flag, .temp_prewarning_flag,
        .chip_thermal_shutdown_flag, .shutdown_safe_latch, .shutdown_delay_extend, .thermal_threshold_raise,
        .tx_enable, .bus_fail, .main_ov_event, .mode
    );
    sts_host_model uc (.clk, .clear_wr, .aux_on_wr, .aux_on_data, .shutdown_delay_extend_wr,
                       .shutdown_delay_extend_data);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // Sample just past the edge so outputs have settled
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_mode(input sts_mode_t m, input int lim);
        n = 0;
        while (mode !== m && n < lim)
        begin
            cyc(1);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        {battery_ok, main_supply_ok, aux_supply_ok, transceiver_supply_ok, transceiver_en} = 5'h1F;
        {main_ov_cmp, aux_hot, bus_hot, main_prewarn_hot, chip_hot, bus_wake, wake_input} = 7'h00;
        {gpio_wake, gpio_is_wake, sleep_req, thermal_threshold_raise_in, rst_n} = 5'h00;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        thermal_threshold_raise_in <= 1'b1;
        cyc(5);
        chk(mode, STS_NORMAL);
        chk({main_supply_en, main_short_flag, chip_thermal_shutdown_flag, aux_enable_bits}, 5'h10);
        chk(thermal_threshold_raise, 1'b1);
        $display("test reset done");
        foreach (rows[i])
        begin
            @(posedge clk);
            bus_hot <= rows[i].bh;
            main_prewarn_hot <= rows[i].pw;
            transceiver_supply_ok <= rows[i].xok;
            cyc(5);
            uc.clr(rows[i].clr);
            cyc(3);
            chk({transceiver_supply_uv_flag, block_thermal_shutdown_flag, temp_prewarning_flag, tx_enable,
                 bus_fail}, rows[i].exp);
        end
        @(posedge clk);
        transceiver_en <= 1'b0;
        transceiver_supply_ok <= 1'b0;
        thermal_threshold_raise_in <= 1'b0;
        cyc(5);
        chk({transceiver_supply_uv_flag, tx_enable, thermal_threshold_raise}, 3'h0);
        @(posedge clk);
        transceiver_supply_ok <= 1'b1;
        cyc(3);
        @(posedge clk);
        transceiver_en <= 1'b1;
        cyc(2);
        chk({transceiver_supply_uv_flag, tx_enable}, 2'h1);
        $display("test table done");
        @(posedge clk);
        aux_hot <= 1'b1;
        cyc(5);
        chk({block_thermal_shutdown_flag, aux_overtemp_flag}, 2'h0);
        @(posedge clk);
        aux_hot <= 1'b0;
        cyc(3);
        uc.wr_aux(2'h3);
        @(posedge clk);
        aux_supply_ok <= 1'b0;
        cyc(BC / 2);
        chk(aux_undervoltage_flag, 1'b0);
        cyc(BC);
        chk({aux_undervoltage_flag, aux_enable_bits}, 3'h7);
        @(posedge clk);
        aux_hot <= 1'b1;
        cyc(5);
        chk({aux_enable_bits, aux_overtemp_flag, block_thermal_shutdown_flag}, 4'h3);
        @(posedge clk);
        aux_hot <= 1'b0;
        aux_supply_ok <= 1'b1;
        cyc(3);
        uc.clr(8'h0D);
        cyc(3);
        chk({aux_undervoltage_flag, aux_overtemp_flag, block_thermal_shutdown_flag}, 3'h0);
        $display("test aux done");
        @(posedge clk);
        sleep_req <= 1'b1;
        chip_hot <= 1'b1;
        cyc(4);
        chk(mode, STS_FAILSAFE);
        chk({chip_thermal_shutdown_flag, fail_output}, 2'h3);
        uc.clr(8'h20);
        cyc(2);
        chk(chip_thermal_shutdown_flag, 1'b1);
        @(posedge clk);
        chip_hot <= 1'b0;
        sleep_req <= 1'b0;
        cyc(3);
        uc.clr(8'h20);
        cyc(1);
        chk(chip_thermal_shutdown_flag, 1'b1);
        wait_mode(STS_RESTART, 40);
        chk(mode, STS_RESTART);
        chk(n + 6 >= CC, 1'b1);
        cyc(1);
        chk(mode, STS_NORMAL);
        uc.clr(8'h20);
        cyc(2);
        chk(chip_thermal_shutdown_flag, 1'b0);
        $display("test chip done");
        uc.wr_ext(1'b1);
        cyc(2);
        chk(shutdown_delay_extend, 1'b1);
        for (int i = 0; i < EVENT_LIMIT; i++)
        begin
            if (i == EVENT_LIMIT - 1)
                chk(shutdown_safe_latch, 1'b0);
            @(posedge clk);
            chip_hot <= 1'b1;
            cyc(5);
            @(posedge clk);
            chip_hot <= 1'b0;
            wait_mode(STS_NORMAL, 1000);
        end
        chk(shutdown_safe_latch, 1'b1);
        chk(n >= COOL_EXT_FACTOR * CC && n < COOL_EXT_FACTOR * CC + 20, 1'b1);
        uc.clr(8'h60);
        cyc(2);
        chk({shutdown_safe_latch, chip_thermal_shutdown_flag}, 2'h0);
        $display("test counter done");
        @(posedge clk);
        sleep_req <= 1'b1;
        cyc(2);
        chk(mode, STS_SLEEP);
        @(posedge clk);
        sleep_req <= 1'b0;
        bus_wake <= 1'b1;
        cyc(5);
        chk(mode, STS_NORMAL);
        @(posedge clk);
        bus_wake <= 1'b0;
        $display("test sleep done");
        @(posedge clk);
        main_ov_cmp <= 1'b1;
        n = 0;
        while (main_ov_event !== 1'b1 && n < 9000)
        begin
            cyc(1);
            n++;
        end
        chk(n >= 5100 && n <= 8000, 1'b1);
        $display("test overvoltage done");
        @(posedge clk);
        main_ov_cmp <= 1'b0;
        battery_ok <= 1'b0;
        main_supply_ok <= 1'b0;
        cyc(3 * SC);
        chk({main_short_flag, mode}, {1'b0, STS_NORMAL});
        @(posedge clk);
        battery_ok <= 1'b1;
        cyc(SC - 5);
        chk(main_short_flag, 1'b0);
        cyc(15);
        chk({main_short_flag, flag_a, fail_output, main_supply_en, mode}, {4'hE, STS_FAILSAFE});
        @(posedge clk);
        gpio_wake <= 1'b1;
        cyc(5);
        chk(mode, STS_FAILSAFE);
        @(posedge clk);
        gpio_is_wake <= 1'b1;
        cyc(3);
        chk(mode, STS_NORMAL);
        @(posedge clk);
        gpio_wake <= 1'b0;
        gpio_is_wake <= 1'b0;
        cyc(SC);
        chk({main_supply_en, mode}, {1'b0, STS_FAILSAFE});
        @(posedge clk);
        wake_input <= 1'b1;
        cyc(5);
        chk(mode !== STS_FAILSAFE, 1'b1);
        $display("test short done");
        finish_test();
    end
endmodule // testbench
